// ### src/prc_top.sv
/*
 * Position reference conditioning: reference smoothing, vibration suppression
 * settings, positioning-complete output with routing, interrupts, Wishbone.
 * Assumes inputs synchronous to I_SYS_CLK and a classic Wishbone master.
 */
// Notes on behaviour
// - Filter order 0 first-order, 1 second-order; taken at restart.
// - Smoothing time constant 0..32767 x0.1ms, default 0, accepted at once.
// - New time constant used only with no pulses and zero error.
// - Suppression enable field 1 on, 0 off; taken at restart.
// - Suppression frequency 50..500 x0.1Hz, default 100, applied at once.
// - Suppression damping 0..200, default 25, applied at once.
// - Suppression active in speed and position modes when enabled.
// - Complete output low when finished, high while incomplete.
// - Complete only while error below threshold.
// - Error must stay below threshold longer than settle time.
// - Threshold 0..5000 reference units, default 10, applied at once.
// - Complete output routable to a selectable terminal.
// - Speed mode gives speed coincidence; torque mode holds high.
// - Clear input low zeroes error counter and stops position loop.
module prc_top
	import prc_pkg::*;
#(
	parameter int NUM_TERMS = prc_pkg::NUM_OUT_TERMS,
	parameter int ERR_W = 32
) (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	// Wishbone slave
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	// Reference and feedback
	input wire logic I_REF_PULSE,
	input wire logic I_REF_DIR,
	input wire logic I_MOTOR_STEP,
	input wire logic I_MOTOR_DIR,
	input wire logic I_ERROR_CLEAR_N,
	input wire logic I_SPEED_COINCIDE,
	// Outputs
	output logic signed [ERR_W-1:0] O_SMOOTH_REF,
	output logic O_POS_LOOP_EN,
	output logic O_VIB_ACTIVE,
	output logic [15:0] O_VIB_FREQ,
	output logic [15:0] O_VIB_DAMP,
	output logic [NUM_TERMS-1:0] O_TERM_N,
	output logic O_IRQ
);
	import prc_pkg::*;

	// ==========================================================
	// Registers
	// ==========================================================
	logic [15:0] smoothing_time_constant;
	logic [15:0] smoothing_filter_order = RST_SMOOTH_ORDER;
	logic [15:0] vibration_suppress_control = RST_VIB_CTRL;
	logic [15:0] vibration_frequency;
	logic [15:0] vibration_damping;
	logic [15:0] completion_error_threshold;
	logic [15:0] completion_settle_time;
	logic [15:0] output_terminal_assign;
	logic [1:0] ctrl_mode;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic order_live;
	logic vib_en_live;
	logic power_up_done;
	logic [15:0] tc_live;
	logic signed [ERR_W-1:0] ref_count;
	logic signed [ERR_W-1:0] pos_error;
	logic [15:0] settle_cnt;
	logic [15:0] tick_cnt;
	logic complete;
	logic ack;

	// ==========================================================
	// Bus decode
	// ==========================================================
	wire logic bus_req = I_WB_CYC && I_WB_STB && !ack;
	wire logic bus_wr = bus_req && I_WB_WE && I_WB_SEL[0] && I_WB_SEL[1];
	wire logic [15:0] wdat = I_WB_DAT[15:0];
	wire logic wr_tc = bus_wr && I_WB_ADR == ADDR_SMOOTH_TC;
	wire logic wr_order = bus_wr && I_WB_ADR == ADDR_SMOOTH_ORDER;
	wire logic wr_vctl = bus_wr && I_WB_ADR == ADDR_VIB_CTRL;
	wire logic wr_vfreq = bus_wr && I_WB_ADR == ADDR_VIB_FREQ;
	wire logic wr_vdamp = bus_wr && I_WB_ADR == ADDR_VIB_DAMP;
	wire logic wr_thr = bus_wr && I_WB_ADR == ADDR_ERR_THRESH;
	wire logic wr_settle = bus_wr && I_WB_ADR == ADDR_SETTLE;
	wire logic wr_assign = bus_wr && I_WB_ADR == ADDR_OUT_ASSIGN;
	wire logic wr_mode = bus_wr && I_WB_ADR == ADDR_MODE;
	wire logic wr_istat = bus_wr && I_WB_ADR == ADDR_IRQ_STAT;
	wire logic wr_imask = bus_wr && I_WB_ADR == ADDR_IRQ_MASK;

	// Out-of-range writes are clamped so the control path never sees a bad value
	wire logic [15:0] tc_in = (wdat > MAX_SMOOTH_TC) ? MAX_SMOOTH_TC : wdat;
	wire logic [15:0] vf_in = (wdat < MIN_VIB_FREQ) ? MIN_VIB_FREQ :
		((wdat > MAX_VIB_FREQ) ? MAX_VIB_FREQ : wdat);
	wire logic [15:0] vd_in = (wdat > MAX_VIB_DAMP) ? MAX_VIB_DAMP : wdat;
	wire logic [15:0] th_in = (wdat > MAX_ERR_THRESH) ? MAX_ERR_THRESH : wdat;
	wire logic [15:0] st_in = (wdat > MAX_SETTLE) ? MAX_SETTLE : wdat;

	// ==========================================================
	// Time base: one pulse each 0.1 ms
	// ==========================================================
	wire logic tick = (tick_cnt == 16'(TICK_CYCLES - 1));

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET || tick)
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick_cnt + 16'h0001;
	end

	// ==========================================================
	// Reference and error counting
	// ==========================================================
	wire logic clear_active = !I_ERROR_CLEAR_N;
	wire logic signed [ERR_W-1:0] ref_delta = I_REF_PULSE ?
		(I_REF_DIR ? -ERR_W'(1) : ERR_W'(1)) : '0;
	wire logic signed [ERR_W-1:0] mot_delta = I_MOTOR_STEP ?
		(I_MOTOR_DIR ? -ERR_W'(1) : ERR_W'(1)) : '0;
	wire logic pos_mode = ctrl_mode == PRC_MODE_POS;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ref_count <= '0;
			pos_error <= '0;
		end else if (clear_active) begin
			pos_error <= '0;
		end else begin
			ref_count <= ref_count + ref_delta;
			pos_error <= pos_error + ref_delta - mot_delta;
		end
	end

	assign O_POS_LOOP_EN = !clear_active && pos_mode;

	// ==========================================================
	// Smoothing time constant adoption
	// ==========================================================
	wire logic quiet = !I_REF_PULSE && pos_error == '0;
	wire logic tc_apply = quiet && tc_live != smoothing_time_constant;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET)
			tc_live <= RST_SMOOTH_TC;
		else if (tc_apply)
			tc_live <= smoothing_time_constant;
	end

	// Shift approximates the time constant in ticks as a power of two
	logic [4:0] tc_shift;
	always_comb begin
		tc_shift = 5'd0;
		for (int b = 0; b < 16; b++) begin
			if (tc_live[b])
				tc_shift = 5'(b + 1);
		end
	end

	// Order and enable are caught one cycle after reset release only
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			power_up_done <= 1'b0;
			order_live <= 1'b0;
			vib_en_live <= 1'b0;
		end else if (!power_up_done) begin
			power_up_done <= 1'b1;
			order_live <= smoothing_filter_order[0];
			vib_en_live <= vibration_suppress_control[VIB_EN_BIT];
		end
	end

	prc_smooth_filter #(
		.W(ERR_W)
	) u_filter (
		.i_clk(I_SYS_CLK),
		.i_reset(I_RESET),
		.i_tick(tick),
		.i_second_order(order_live),
		.i_shift(tc_shift),
		.i_target(ref_count),
		.o_value(O_SMOOTH_REF)
	);

	// ==========================================================
	// Vibration suppression
	// ==========================================================
	assign O_VIB_ACTIVE = vib_en_live && ctrl_mode != PRC_MODE_TORQUE;
	assign O_VIB_FREQ = vibration_frequency;
	assign O_VIB_DAMP = vibration_damping;

	// ==========================================================
	// Positioning complete
	// ==========================================================
	wire logic signed [ERR_W-1:0] abs_err = (pos_error < 0) ? -pos_error : pos_error;
	wire logic below = abs_err < $signed({{(ERR_W-16){1'b0}}, completion_error_threshold});
	wire logic settled = settle_cnt > completion_settle_time;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET || !below || clear_active) begin
			settle_cnt <= 16'h0000;
			complete <= 1'b0;
		end else begin
			if (tick && settle_cnt != 16'hFFFF)
				settle_cnt <= settle_cnt + 16'h0001;
			complete <= settled;
		end
	end

	// Mode picks what drives the shared signal
	wire logic sig_on = (ctrl_mode == PRC_MODE_POS) ? complete :
		(ctrl_mode == PRC_MODE_SPEED) ? I_SPEED_COINCIDE : 1'b0;
	wire logic prev_complete_set = complete;
	logic complete_d;

	// Active-low terminal drive, selectable terminal
	logic [NUM_TERMS-1:0] term_n;
	genvar t;
	generate
		for (t = 0; t < NUM_TERMS; t++) begin : g_term
			always_ff @(posedge I_SYS_CLK) begin
				if (I_RESET)
					term_n[t] <= 1'b1;
				else
					term_n[t] <= !(sig_on &&
						output_terminal_assign[1:0] == 2'(t));
			end
		end
	endgenerate
	assign O_TERM_N = term_n;

	// ==========================================================
	// Interrupts
	// ==========================================================
	wire logic [2:0] irq_evt = {tc_apply, complete_d && !complete,
		!complete_d && prev_complete_set};

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			complete_d <= 1'b0;
			irq_stat <= 3'h0;
		end else begin
			complete_d <= complete;
			// Set wins over a simultaneous write-one clear
			irq_stat <= (irq_stat & ~(wr_istat ? wdat[2:0] : 3'h0)) | irq_evt;
		end
	end

	assign O_IRQ = |(irq_stat & irq_mask);

	// ==========================================================
	// Register writes
	// ==========================================================
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			smoothing_time_constant <= RST_SMOOTH_TC;
			vibration_frequency <= RST_VIB_FREQ;
			vibration_damping <= RST_VIB_DAMP;
			completion_error_threshold <= RST_ERR_THRESH;
			completion_settle_time <= RST_SETTLE;
			output_terminal_assign <= RST_OUT_ASSIGN;
			ctrl_mode <= PRC_MODE_POS;
			irq_mask <= 3'h0;
		end else begin
			if (wr_tc)
				smoothing_time_constant <= tc_in;
			if (wr_vfreq)
				vibration_frequency <= vf_in;
			if (wr_vdamp)
				vibration_damping <= vd_in;
			if (wr_thr)
				completion_error_threshold <= th_in;
			if (wr_settle)
				completion_settle_time <= st_in;
			if (wr_assign)
				output_terminal_assign <= wdat & 16'(NUM_TERMS - 1);
			if (wr_mode && wdat[1:0] != 2'h3)
				ctrl_mode <= wdat[1:0];
			if (wr_imask)
				irq_mask <= wdat[2:0];
		end
	end

	// Stored settings outlive a restart, so a new order or enable takes hold at the next one
	// Power-on values come from the declarations; clearing them on reset would lose the write
	always_ff @(posedge I_SYS_CLK) begin
		if (wr_order)
			smoothing_filter_order <= {15'h0000, wdat[0]};
		if (wr_vctl)
			vibration_suppress_control <= wdat;
	end

	// ==========================================================
	// Read path: unmapped reads return zero, every access is acked
	// ==========================================================
	logic [31:0] rd;
	always_comb begin
		unique case (I_WB_ADR)
			ADDR_SMOOTH_TC: rd = {16'h0000, smoothing_time_constant};
			ADDR_SMOOTH_ORDER: rd = {16'h0000, smoothing_filter_order};
			ADDR_VIB_CTRL: rd = {16'h0000, vibration_suppress_control};
			ADDR_VIB_FREQ: rd = {16'h0000, vibration_frequency};
			ADDR_VIB_DAMP: rd = {16'h0000, vibration_damping};
			ADDR_ERR_THRESH: rd = {16'h0000, completion_error_threshold};
			ADDR_SETTLE: rd = {16'h0000, completion_settle_time};
			ADDR_OUT_ASSIGN: rd = {16'h0000, output_terminal_assign};
			ADDR_MODE: rd = {30'h0000_0000, ctrl_mode};
			ADDR_STATUS: rd = {28'h000_0000, vib_en_live, order_live, O_POS_LOOP_EN, complete};
			ADDR_IRQ_STAT: rd = {29'h0000_0000, irq_stat};
			ADDR_IRQ_MASK: rd = {29'h0000_0000, irq_mask};
			ADDR_ERROR: rd = 32'(pos_error);
			ADDR_ACTIVE: rd = {16'h0000, tc_live};
			default: rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			ack <= 1'b0;
			O_WB_DAT <= 32'h0000_0000;
		end else begin
			ack <= bus_req;
			if (bus_req)
				O_WB_DAT <= rd;
		end
	end

	assign O_WB_ACK = ack;
endmodule

// ### src/prc_pkg.sv
/*
 * Package for the position reference conditioning block: register offsets,
 * reset values, field positions, modes and timing constants.
 * Assumes a 40 MHz system clock and a 32-bit classic Wishbone slave port.
 */
package prc_pkg;

	// ==========================================================
	// Clock and time base
	// ==========================================================
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_US = 100;
	localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

	// ==========================================================
	// Register offsets (byte addresses)
	// ==========================================================
	localparam logic [7:0] ADDR_SMOOTH_TC = 8'h00;
	localparam logic [7:0] ADDR_SMOOTH_ORDER = 8'h04;
	localparam logic [7:0] ADDR_VIB_CTRL = 8'h08;
	localparam logic [7:0] ADDR_VIB_FREQ = 8'h0C;
	localparam logic [7:0] ADDR_VIB_DAMP = 8'h10;
	localparam logic [7:0] ADDR_ERR_THRESH = 8'h14;
	localparam logic [7:0] ADDR_SETTLE = 8'h18;
	localparam logic [7:0] ADDR_OUT_ASSIGN = 8'h1C;
	localparam logic [7:0] ADDR_MODE = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
	localparam logic [7:0] ADDR_ERROR = 8'h30;
	localparam logic [7:0] ADDR_ACTIVE = 8'h34;

	// ==========================================================
	// Reset values and limits
	// ==========================================================
	localparam logic [15:0] RST_SMOOTH_TC = 16'h0000;
	localparam logic [15:0] RST_SMOOTH_ORDER = 16'h0000;
	localparam logic [15:0] RST_VIB_CTRL = 16'h0000;
	localparam logic [15:0] RST_VIB_FREQ = 16'h0064;
	localparam logic [15:0] RST_VIB_DAMP = 16'h0019;
	localparam logic [15:0] RST_ERR_THRESH = 16'h000A;
	localparam logic [15:0] RST_SETTLE = 16'h01F4;
	localparam logic [15:0] RST_OUT_ASSIGN = 16'h0000;
	localparam logic [15:0] MAX_SMOOTH_TC = 16'h7FFF;
	localparam logic [15:0] MIN_VIB_FREQ = 16'h0032;
	localparam logic [15:0] MAX_VIB_FREQ = 16'h01F4;
	localparam logic [15:0] MAX_VIB_DAMP = 16'h00C8;
	localparam logic [15:0] MAX_ERR_THRESH = 16'h1388;
	localparam logic [15:0] MAX_SETTLE = 16'hEA60;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int VIB_EN_BIT = 8;
	localparam int NUM_OUT_TERMS = 4;
	localparam int IRQ_COMPLETE = 0;
	localparam int IRQ_RELEASE = 1;
	localparam int IRQ_TC_APPLY = 2;

	// ==========================================================
	// Control modes
	// ==========================================================
	typedef enum logic [1:0] {
		PRC_MODE_POS = 2'h0,
		PRC_MODE_SPEED = 2'h1,
		PRC_MODE_TORQUE = 2'h2
	} prc_mode_t;

endpackage

// ### src/prc_smooth_filter.sv
/*
 * Reference smoothing filter: one or two cascaded first-order stages on the
 * incoming reference step stream.
 * Assumes a one-cycle tick every 0.1 ms and a constant shift derived from the
 * time constant by the caller.
 */
module prc_smooth_filter #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Control
	input wire logic i_tick,
	input wire logic i_second_order,
	input wire logic [4:0] i_shift,
	input wire logic signed [W-1:0] i_target,
	// Output
	output logic signed [W-1:0] o_value
);
	logic signed [W-1:0] stage1;
	logic signed [W-1:0] stage2;
	wire logic signed [W-1:0] step1 = (i_target - stage1) >>> i_shift;
	wire logic signed [W-1:0] step2 = (stage1 - stage2) >>> i_shift;
	wire logic signed [W-1:0] inc1 = (step1 == '0 && i_target != stage1) ?
		((i_target > stage1) ? W'(1) : -W'(1)) : step1;
	wire logic signed [W-1:0] inc2 = (step2 == '0 && stage1 != stage2) ?
		((stage1 > stage2) ? W'(1) : -W'(1)) : step2;

	// ==========================================================
	// Stages
	// ==========================================================
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stage1 <= '0;
			stage2 <= '0;
		end else if (i_tick) begin
			stage1 <= stage1 + inc1;
			stage2 <= stage2 + inc2;
		end
	end

	assign o_value = i_second_order ? stage2 : stage1;
endmodule

// ### sim/prc_props.sv
/*
 * Checker for the port behaviour of prc_top.
 * Assumes it is bound to prc_top and clocked by its system clock.
 */
module prc_props
	import prc_pkg::*;
#(
	parameter int NUM_TERMS = 4
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	input wire logic O_WB_ACK,
	input wire logic I_ERROR_CLEAR_N,
	input wire logic O_POS_LOOP_EN,
	input wire logic [15:0] O_VIB_FREQ,
	input wire logic [15:0] O_VIB_DAMP,
	input wire logic [NUM_TERMS-1:0] O_TERM_N,
	input wire logic O_IRQ
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Helpers
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RESET);
	int unsigned since_rst;
	logic wr_freq;
	logic [15:0] wr_val;
	assign wr_val = I_WB_DAT[15:0];
	assign wr_freq = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK && (I_WB_ADR == ADDR_VIB_FREQ)
		&& (I_WB_SEL[1:0] == 2'b11) && (wr_val >= MIN_VIB_FREQ) && (wr_val <= MAX_VIB_FREQ);
	// Saturates so a long run never wraps back into the settle window
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			since_rst <= 0;
		end else if (since_rst < 20000) begin
			since_rst <= since_rst + 1;
		end
	end
	// ==========================================================
	// Assertions
	ack_answer_a:
		assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("no ack");
	ack_pulse_a:
		assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held");
	ack_idle_a:
		assert property (!I_WB_STB |=> !O_WB_ACK) else $error("ack without request");
	loop_clear_a:
		assert property (!I_ERROR_CLEAR_N |-> !O_POS_LOOP_EN) else $error("loop on in clear");
	one_term_a:
		assert property ($onehot0(~O_TERM_N)) else $error("two terminals low");
	term_reset_a:
		assert property ($past(I_RESET) |-> (&O_TERM_N) && !O_IRQ) else $error("bad reset out");
	settle_min_a:
		assert property (!(&O_TERM_N) |-> since_rst > 3990) else $error("complete too soon");
	freq_range_a:
		assert property (O_VIB_FREQ >= MIN_VIB_FREQ && O_VIB_FREQ <= MAX_VIB_FREQ)
		else $error("freq out of range");
	damp_range_a:
		assert property (O_VIB_DAMP <= MAX_VIB_DAMP) else $error("damp out of range");
	vib_reset_a:
		assert property ($past(I_RESET) |-> O_VIB_FREQ == RST_VIB_FREQ && O_VIB_DAMP == RST_VIB_DAMP)
		else $error("vib reset value");
	freq_write_a:
		assert property (wr_freq |=> O_VIB_FREQ == $past(wr_val)) else $error("freq not applied");
endmodule

// ### sim/prc_host_model.sv
/*
 * Host controller model: bursts of reference pulses and motor steps.
 * Assumes requests arrive from the bench on the rising clock edge.
 */
module prc_host_model (
	// Clock
	input wire logic i_clk,
	// Request
	input wire logic i_go,
	input wire logic i_slow,
	input wire logic i_dir,
	input wire logic [7:0] i_ref_cnt,
	input wire logic [7:0] i_mot_cnt,
	// Pulse lines
	output logic o_ref_pulse = 1'b0,
	output logic o_motor_step = 1'b0,
	output logic o_dir = 1'b0,
	output logic o_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Pulse engine
	logic [7:0] ref_left = 8'h00;
	logic [7:0] mot_left = 8'h00;
	logic hold = 1'b0;
	logic fire;
	// Pulses assume a reduced 1/1 gear, inside 0.01..100
	// Slow mode leaves a gap so the design never relies on back-to-back steps
	assign fire = !(i_slow && hold);
	// Busy until the last pulse has left, so the bench only clears once pulses stop
	assign o_busy = (ref_left != 8'h00) || (mot_left != 8'h00) || o_ref_pulse || o_motor_step;
	always @(posedge i_clk) begin
		hold <= !hold;
		o_ref_pulse <= fire && (ref_left != 8'h00);
		o_motor_step <= fire && (mot_left != 8'h00);
		if (i_go) begin
			ref_left <= i_ref_cnt;
			mot_left <= i_mot_cnt;
			o_dir <= i_dir;
		end else if (fire) begin
			ref_left <= ref_left - 8'(ref_left != 8'h00);
			mot_left <= mot_left - 8'(mot_left != 8'h00);
		end
	end
endmodule

// ### sim/prc_top_bench.sv
/*
 * Self-checking bench for prc_top driven by a host pulse model.
 * Assumes one settle tick every 4000 clocks at 40 MHz.
 */
module prc_top_bench;
	import prc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Signals
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic clr_n = 1'b1;
	logic positioning_complete_n = 1'b0;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic dir = 1'b0;
	logic [7:0] nref = 8'h00;
	logic [7:0] nmot = 8'h00;
	logic [31:0] rdat;
	logic ack, refp, mstep, hdir, busy, loop_en, vib_act, irq;
	logic [15:0] vfreq, vdamp, rv;
	logic [3:0] term_n;
	logic signed [31:0] sref;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [15:0] rst_v[7] = '{RST_SMOOTH_TC, RST_SMOOTH_ORDER, RST_VIB_CTRL, RST_VIB_FREQ,
		RST_VIB_DAMP, RST_ERR_THRESH, RST_SETTLE};
	logic [7:0] c_adr[6] = '{ADDR_SMOOTH_TC, ADDR_VIB_FREQ, ADDR_VIB_FREQ, ADDR_VIB_DAMP,
		ADDR_ERR_THRESH, ADDR_SETTLE};
	logic [15:0] c_wr[6] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	logic [15:0] c_exp[6] = '{MAX_SMOOTH_TC, MIN_VIB_FREQ, MAX_VIB_FREQ, MAX_VIB_DAMP,
		MAX_ERR_THRESH, MAX_SETTLE};
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	prc_top u_dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_REF_PULSE(refp), .I_REF_DIR(hdir), .I_MOTOR_STEP(mstep), .I_MOTOR_DIR(hdir),
		.I_ERROR_CLEAR_N(clr_n), .I_SPEED_COINCIDE(positioning_complete_n), .O_SMOOTH_REF(sref),
		.O_POS_LOOP_EN(loop_en), .O_VIB_ACTIVE(vib_act), .O_VIB_FREQ(vfreq), .O_VIB_DAMP(vdamp),
		.O_TERM_N(term_n), .O_IRQ(irq));
	prc_host_model u_host (.i_clk(clk), .i_go(go), .i_slow(slow), .i_dir(dir), .i_ref_cnt(nref),
		.i_mot_cnt(nmot), .o_ref_pulse(refp), .o_motor_step(mstep), .o_dir(hdir), .o_busy(busy));
	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Holds the request until ack is seen at an edge; only the bench timeout ends a wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		{cyc, stb, we} <= 3'b000;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		wb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic host(input logic [7:0] r, input logic [7:0] m, input logic s);
		{go, nref, nmot, slow} <= {1'b1, r, m, s};
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy) @(posedge clk);
	endtask
	// ==========================================================
	// Clock, read monitor, timeout
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check(rdat & msk_q.pop_front(), exp_q.pop_front());
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			test_done();
		end
	end
	// ==========================================================
	// Scenarios
	initial begin
		rv = 16'($urandom(85));
		tick(3);
		rst <= 1'b0;
		tick(1);
		for (int i = 0; i < 7; i++) rd(8'(i * 4), {16'h0000, rst_v[i]}, ALL);
		wb(1'b1, 8'h3C, 32'h0000_FFFF);
		rd(8'h3C, 32'h0000_0000, ALL);
		$display("Test defaults done");
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, c_adr[i], {16'hFFFF, c_wr[i]});
			rd(c_adr[i], {16'h0000, c_exp[i]}, ALL);
		end
		rd(ADDR_ACTIVE, {16'h0000, MAX_SMOOTH_TC}, ALL);
		rv = 16'(50 + $urandom_range(450));
		wb(1'b1, ADDR_VIB_FREQ, {16'h0000, rv});
		check({16'h0000, vfreq}, {16'h0000, rv});
		rv = 16'($urandom_range(200));
		wb(1'b1, ADDR_VIB_DAMP, {16'h0000, rv});
		rd(ADDR_VIB_DAMP, {16'h0000, rv}, ALL);
		check({16'h0000, vdamp}, {16'h0000, rv});
		$display("Test ranges done");
		wb(1'b1, ADDR_SETTLE, 32'h0000_0002);
		wb(1'b1, ADDR_OUT_ASSIGN, 32'h0000_0001);
		wb(1'b1, ADDR_ERR_THRESH, 32'h0000_0014);
		wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
		dir <= 1'($urandom_range(1));
		clr_n <= 1'b0;
		tick(2);
		check(32'(loop_en), 32'h0000_0000);
		clr_n <= 1'b1;
		tick(7900);
		check(32'(term_n), 32'h0000_000F);
		tick(4200);
		check(32'(term_n), 32'h0000_000D);
		rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
		check(32'(irq), 32'h0000_0000);
		host(8'd10, 8'd0, 1'b0);
		check(32'(term_n), 32'h0000_000D);
		host(8'd10, 8'd0, 1'b1);
		tick(3);
		check(32'(term_n), 32'h0000_000F);
		check(32'(irq), 32'h0000_0001);
		rd(ADDR_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
		wb(1'b1, ADDR_IRQ_STAT, 32'h0000_0002);
		check(32'(irq), 32'h0000_0000);
		$display("Test completion done");
		wb(1'b1, ADDR_IRQ_STAT, 32'h0000_0004);
		wb(1'b1, ADDR_SMOOTH_TC, 32'h0000_0005);
		rd(ADDR_ACTIVE, {16'h0000, MAX_SMOOTH_TC}, ALL);
		host(8'd0, 8'd20, 1'b0);
		tick(4);
		rd(ADDR_ACTIVE, 32'h0000_0005, ALL);
		rd(ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
		$display("Test smoothing done");
		wb(1'b1, ADDR_MODE, 32'h0000_0001);
		positioning_complete_n <= 1'b1;
		tick(3);
		check(32'(term_n), 32'h0000_000D);
		positioning_complete_n <= 1'b0;
		tick(3);
		check(32'(term_n), 32'h0000_000F);
		wb(1'b1, ADDR_MODE, 32'h0000_0002);
		positioning_complete_n <= 1'b1;
		tick(3);
		check(32'(term_n), 32'h0000_000F);
		check(32'(vib_act), 32'h0000_0000);
		positioning_complete_n <= 1'b0;
		wb(1'b1, ADDR_MODE, 32'h0000_0000);
		$display("Test modes done");
		wb(1'b1, ADDR_VIB_CTRL, 32'h0000_0100);
		wb(1'b1, ADDR_SMOOTH_ORDER, 32'h0000_0001);
		rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_000C);
		check(32'(vib_act), 32'h0000_0000);
		rst <= 1'b1;
		tick(3);
		rst <= 1'b0;
		tick(1);
		rd(ADDR_IRQ_STAT, 32'h0000_0000, ALL);
		check(32'(irq), 32'h0000_0000);
		rd(ADDR_STATUS, 32'h0000_000C, 32'h0000_000C);
		check(32'(vib_act), 32'h0000_0001);
		host(8'd5, 8'd5, 1'b0);
		tick(6000);
		check(sref, 32'h0000_0000);
		tick(2100);
		check(sref, dir ? 32'hFFFF_FFFB : 32'h0000_0005);
		wb(1'b1, ADDR_MODE, 32'h0000_0001);
		check(32'(vib_act), 32'h0000_0001);
		$display("Test restart done");
		test_done();
	end
endmodule

bind prc_top prc_props #(.NUM_TERMS(NUM_TERMS)) u_props (.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET),
	.I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
	.I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK),
	.I_ERROR_CLEAR_N(I_ERROR_CLEAR_N), .O_POS_LOOP_EN(O_POS_LOOP_EN), .O_VIB_FREQ(O_VIB_FREQ),
	.O_VIB_DAMP(O_VIB_DAMP), .O_TERM_N(O_TERM_N), .O_IRQ(O_IRQ));
